// ### rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    // Number of interrupt sources
    localparam int NUM_SRC = 12;
    // Source index, also the order of the request and vector tables
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_SER = 4;
    localparam int SRC_BOD = 5;
    localparam int SRC_TWI = 6;
    localparam int SRC_KBD = 7;
    localparam int SRC_CMP2 = 8;
    localparam int SRC_WDT = 9;
    localparam int SRC_CMP1 = 10;
    localparam int SRC_BTMR = 11;

    // Enable register A bit positions
    localparam int ENA_EXT0 = 0;
    localparam int ENA_TMR0 = 1;
    localparam int ENA_EXT1 = 2;
    localparam int ENA_TMR1 = 3;
    localparam int ENA_SER = 4;
    localparam int ENA_BOD = 5;
    localparam int ENA_WDT = 6;
    localparam int ENA_GLOBAL = 7;
    // Enable register B bit positions
    localparam int ENB_TWI = 0;
    localparam int ENB_KBD = 1;
    localparam int ENB_CMP2 = 2;
    localparam int ENB_CMP1 = 5;
    localparam int ENB_BTMR = 7;

    // Reset value of every control register
    localparam logic [7:0] REG_RST = 8'h00;

    // Vector addresses, indexed by source
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001b;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [15:0] VEC_BOD = 16'h002b;
    localparam logic [15:0] VEC_TWI = 16'h0033;
    localparam logic [15:0] VEC_KBD = 16'h003b;
    localparam logic [15:0] VEC_CMP2 = 16'h0043;
    localparam logic [15:0] VEC_WDT = 16'h0053;
    localparam logic [15:0] VEC_CMP1 = 16'h0063;
    localparam logic [15:0] VEC_BTMR = 16'h0073;

    // Sources able to wake the core from power down
    localparam logic [11:0] WAKE_MASK = 12'h7a5;

    // Tie-break polling order, first entry wins
    localparam int RANK_0 = SRC_EXT0;
    localparam int RANK_1 = SRC_BOD;
    localparam int RANK_2 = SRC_WDT;
    localparam int RANK_3 = SRC_TMR0;
    localparam int RANK_4 = SRC_TWI;
    localparam int RANK_5 = SRC_EXT1;
    localparam int RANK_6 = SRC_KBD;
    localparam int RANK_7 = SRC_CMP1;
    localparam int RANK_8 = SRC_TMR1;
    localparam int RANK_9 = SRC_CMP2;
    localparam int RANK_10 = SRC_SER;
    localparam int RANK_11 = SRC_BTMR;

    // CPU clocks per machine cycle, and the least pin hold time
    localparam int CLK_PER_MC = 6;
    localparam int MIN_HOLD_CLK = 6;
    localparam logic [2:0] MC_LAST = 3'(CLK_PER_MC - 1);

    // Top priority level and the depth of the level stack
    localparam logic [1:0] LVL_TOP = 2'h3;
    localparam int STACK_DEPTH = 4;

    // Handshake states toward the core
    typedef enum logic [1:0] {ST_IDLE, ST_OFFER} ack_state_t;

endpackage

// ### rtl/interrupt_priority_controller.sv
// Summary of operation
// RL1: Twelve sources sorted into four levels.
// RL2: Per-source enables plus one global block.
// RL3: Two priority bits per source, high low.
// RL4: Only strictly higher level preempts a handler.
// RL5: Higher level wins among simultaneous requests.
// RL6: Fixed polling order breaks ties within level.
// RL7: Fixed vector address for each source.
// RL8: Tie order ext0 bod wdt tmr0 and rest.
// RL9: Enable bits placed in two enable registers.
// RL10: Only seven listed sources wake power down.
// RL11: Trigger type zero: low level requests.
// RL12: Trigger type one: high-then-low sample sets flag.
// RL13: Pins sampled once per six-clock machine cycle.
// RL14: Source holds high then low each cycle.
// RL15: Edge flag cleared when core takes vector.
// RL16: Level source holds low until taken.
// RL17: Level flag simply follows the pin.
// RL18: Pin still low after return re-requests.
// RL19: Enabled external interrupt wakes idle, power down.
// RL20: Active level tracked and restored on return.
// RL21: Global enable is top bit, resets zero.
`timescale 1ns/10ps
module interrupt_priority_controller
    import irq_ctrl_pkg::*;
(
    input wire logic clk, // CPU clock, 20 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [7:0] enable_reg_a, // Enable register A
    input wire logic [7:0] enable_reg_b, // Enable register B
    input wire logic [7:0] prio_low_a, // Priority low bits A
    input wire logic [7:0] prio_high_a, // Priority high bits A
    input wire logic [7:0] prio_low_b, // Priority low bits B
    input wire logic [7:0] prio_high_b, // Priority high bits B
    input wire logic ext0_trigger_type, // 1 edge, 0 level, ext 0
    input wire logic ext1_trigger_type, // 1 edge, 0 level, ext 1
    input wire logic ext_irq_pin_0_n, // External pin 0, low active
    input wire logic ext_irq_pin_1_n, // External pin 1, low active
    input wire logic tmr0_overflow_flag, // Timer 0 request
    input wire logic tmr1_overflow_flag, // Timer 1 request
    input wire logic serial_tx_flag, // Serial transmit request
    input wire logic serial_rx_flag, // Serial receive request
    input wire logic brownout_flag, // Brownout request
    input wire logic twowire_attention_flag, // Two-wire request
    input wire logic keypad_flag, // Keypad request
    input wire logic cmp1_flag, // Comparator 1 request
    input wire logic cmp2_flag, // Comparator 2 request
    input wire logic wdt_overflow_flag, // Watchdog request
    input wire logic bus_timer_flag, // Bus timer request
    input wire logic irq_ack, // Core takes the offered vector
    input wire logic irq_return, // Core returns from handler
    input wire logic power_down, // Core is in power down
    output logic irq_req, // Request to the core
    output logic [15:0] irq_vector, // Vector of offered request
    output logic [3:0] irq_source, // Source index offered
    output logic [1:0] irq_level, // Level of offered request
    output logic ext0_request_flag, // External 0 request flag
    output logic ext1_request_flag, // External 1 request flag
    output logic wakeup, // Wake the core from idle/power down
    output logic [2:0] active_depth // Nested handlers in progress
);
    import irq_ctrl_pkg::*;

    // Vector table by source index
    localparam logic [15:0] VEC_TAB [NUM_SRC] = '{VEC_EXT0, VEC_TMR0,
        VEC_EXT1, VEC_TMR1, VEC_SER, VEC_BOD, VEC_TWI, VEC_KBD,
        VEC_CMP2, VEC_WDT, VEC_CMP1, VEC_BTMR};
    // Polling order table, position 0 polled first
    localparam int RANK_TAB [NUM_SRC] = '{RANK_0, RANK_1, RANK_2,
        RANK_3, RANK_4, RANK_5, RANK_6, RANK_7, RANK_8, RANK_9,
        RANK_10, RANK_11};

    // Machine cycle divider
    logic [2:0] mc_cnt_r;
    logic [2:0] mc_cnt_nxt;
    logic mc_tick; // Last clock of a machine cycle
    // Pin samples, one per machine cycle
    logic [1:0] pin_smp_r;
    logic [1:0] pin_smp_nxt;
    // Edge-mode latched flags
    logic [1:0] edge_flag_r;
    logic [1:0] edge_flag_nxt;
    logic [1:0] fall_seen; // Falling edge seen this tick
    logic [1:0] edge_clr; // Cleared on vector to handler
    logic [1:0] trig_type; // Trigger type per pin
    logic [1:0] ext_flag; // Request flag per pin
    // Request vector and gating
    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] gated_req;
    logic [1:0] src_lvl [NUM_SRC];
    // Level stack of handlers in progress
    logic [1:0] lvl_stack_r [STACK_DEPTH];
    logic [2:0] depth_r;
    logic [2:0] depth_nxt;
    logic [1:0] cur_lvl; // Level of handler now running
    // Arbitration results
    logic win_valid;
    logic [3:0] win_src;
    logic [1:0] win_lvl;
    logic preempt_ok;
    // Offer handshake
    ack_state_t state_r;
    ack_state_t state_nxt;
    logic take;
    logic [15:0] vec_nxt;

    // Priority level of source from its pair of register bits
    function automatic logic [1:0] lvl_of(input logic hi, input logic lo);
        lvl_of = {hi, lo}; // see RL3
    endfunction

    // Machine cycle tick every six CPU clocks
    assign mc_tick = (mc_cnt_r == MC_LAST); // see RL13
    assign mc_cnt_nxt = mc_tick ? 3'h0 : 3'(mc_cnt_r + 3'h1);

    // External pins: sampling, edge detect, level follow
    assign trig_type = {ext1_trigger_type, ext0_trigger_type};
    assign pin_smp_nxt = mc_tick ? {ext_irq_pin_1_n, ext_irq_pin_0_n}
                                 : pin_smp_r; // see RL13
    // High in previous sample, low in this one
    assign fall_seen = pin_smp_r & ~{ext_irq_pin_1_n, ext_irq_pin_0_n}
                       & trig_type & {2{mc_tick}}; // see RL12
    assign edge_clr[0] = take && (win_src == 4'(SRC_EXT0)); // see RL15
    assign edge_clr[1] = take && (win_src == 4'(SRC_EXT1)); // see RL15
    // Setting wins over the clear in the same cycle
    assign edge_flag_nxt = (edge_flag_r & ~edge_clr) | fall_seen;
    // Level mode tracks the sampled pin, edge mode the latch
    assign ext_flag = (trig_type & edge_flag_r)
                      | (~trig_type & ~pin_smp_r); // see RL11 RL17 RL18
    assign ext0_request_flag = ext_flag[0];
    assign ext1_request_flag = ext_flag[1];

    // Requests in source order
    assign raw_req = {bus_timer_flag, cmp1_flag, wdt_overflow_flag,
        cmp2_flag, keypad_flag, twowire_attention_flag, brownout_flag,
        serial_tx_flag | serial_rx_flag, tmr1_overflow_flag,
        ext_flag[1], tmr0_overflow_flag, ext_flag[0]}; // see RL1

    // Enable bits in source order
    assign src_en = {enable_reg_b[ENB_BTMR], enable_reg_b[ENB_CMP1],
        enable_reg_a[ENA_WDT], enable_reg_b[ENB_CMP2],
        enable_reg_b[ENB_KBD], enable_reg_b[ENB_TWI],
        enable_reg_a[ENA_BOD], enable_reg_a[ENA_SER],
        enable_reg_a[ENA_TMR1], enable_reg_a[ENA_EXT1],
        enable_reg_a[ENA_TMR0], enable_reg_a[ENA_EXT0]}; // see RL9
    // Global enable gates every source
    assign gated_req = raw_req & src_en
                       & {NUM_SRC{enable_reg_a[ENA_GLOBAL]}}; // see RL2 RL21

    // Priority per source, bank A for ext0 through brownout and watchdog
    assign src_lvl[SRC_EXT0] = lvl_of(prio_high_a[0], prio_low_a[0]);
    assign src_lvl[SRC_TMR0] = lvl_of(prio_high_a[1], prio_low_a[1]);
    assign src_lvl[SRC_EXT1] = lvl_of(prio_high_a[2], prio_low_a[2]);
    assign src_lvl[SRC_TMR1] = lvl_of(prio_high_a[3], prio_low_a[3]);
    assign src_lvl[SRC_SER] = lvl_of(prio_high_a[4], prio_low_a[4]);
    assign src_lvl[SRC_BOD] = lvl_of(prio_high_a[5], prio_low_a[5]);
    assign src_lvl[SRC_WDT] = lvl_of(prio_high_a[6], prio_low_a[6]);
    assign src_lvl[SRC_TWI] = lvl_of(prio_high_b[0], prio_low_b[0]);
    assign src_lvl[SRC_KBD] = lvl_of(prio_high_b[1], prio_low_b[1]);
    assign src_lvl[SRC_CMP2] = lvl_of(prio_high_b[2], prio_low_b[2]);
    assign src_lvl[SRC_CMP1] = lvl_of(prio_high_b[5], prio_low_b[5]);
    assign src_lvl[SRC_BTMR] = lvl_of(prio_high_b[7], prio_low_b[7]);

    // Arbitration: highest level, then first in polling order
    always_comb begin
        win_valid = 1'b0;
        win_src = 4'h0;
        win_lvl = 2'h0;
        for (int k = 0; k < NUM_SRC; k++) begin
            // Strictly higher level replaces, equal keeps earlier rank
            if (gated_req[RANK_TAB[k]] &&
                (!win_valid || src_lvl[RANK_TAB[k]] > win_lvl)) begin
                win_valid = 1'b1; // see RL5 RL6 RL8
                win_src = 4'(RANK_TAB[k]);
                win_lvl = src_lvl[RANK_TAB[k]];
            end
        end
    end

    // Running level and the preemption test
    assign cur_lvl = (depth_r == 3'h0) ? 2'h0
                     : lvl_stack_r[2'(depth_r - 3'h1)];
    // Idle core takes any level; a handler only a higher one
    assign preempt_ok = win_valid && ((depth_r == 3'h0)
                        || (cur_lvl != LVL_TOP && win_lvl > cur_lvl)); // see RL4

    // Offer handshake toward the core
    assign take = (state_r == ST_OFFER) && irq_ack && preempt_ok;
    always_comb begin
        case (state_r)
            ST_IDLE: state_nxt = preempt_ok ? ST_OFFER : ST_IDLE;
            ST_OFFER: state_nxt = (take || !preempt_ok) ? ST_IDLE
                                                        : ST_OFFER;
            default: state_nxt = ST_IDLE;
        endcase
    end
    assign irq_req = (state_r == ST_OFFER) && preempt_ok;
    assign vec_nxt = VEC_TAB[win_src]; // see RL7

    // Nesting depth: push on take, pop on return
    always_comb begin
        depth_nxt = depth_r;
        if (take && depth_r != 3'(STACK_DEPTH)) begin
            depth_nxt = 3'(depth_r + 3'h1);
        end else if (irq_return && depth_r != 3'h0) begin
            depth_nxt = 3'(depth_r - 3'h1); // see RL20
        end
    end
    assign active_depth = depth_r;

    // Wake: any enabled pending request, in power down only one of a wake-capable source
    assign wakeup = power_down ? |(gated_req & WAKE_MASK)
                               : |gated_req; // see RL10 RL19

    // Level stack entries, one per nesting depth
    generate
        for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_stack
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    lvl_stack_r[g] <= 2'h0;
                end else if (take && depth_r == 3'(g)) begin
                    lvl_stack_r[g] <= win_lvl; // see RL20
                end
            end
        end
    endgenerate

    // Machine cycle, pin samples and edge flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mc_cnt_r <= 3'h0;
            pin_smp_r <= 2'h3;
            edge_flag_r <= 2'h0;
        end else begin
            mc_cnt_r <= mc_cnt_nxt;
            pin_smp_r <= pin_smp_nxt;
            edge_flag_r <= edge_flag_nxt;
        end
    end

    // Handshake state, depth and offered vector registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            depth_r <= 3'h0;
            irq_vector <= 16'h0000;
            irq_source <= 4'h0;
            irq_level <= 2'h0;
        end else begin
            state_r <= state_nxt;
            depth_r <= depth_nxt;
            irq_vector <= vec_nxt;
            irq_source <= win_src;
            irq_level <= win_lvl;
        end
    end

endmodule

// ### testbench/irq_ctrl_checker.sv
`timescale 1ns/10ps
module irq_ctrl_checker (
    input wire logic clk, // CPU clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic [7:0] enable_reg_a, // Enable register A
    input wire logic [7:0] prio_low_a, // Priority low bits A
    input wire logic [7:0] prio_high_a, // Priority high bits A
    input wire logic ext0_trigger_type, // Trigger type, ext 0
    input wire logic ext_irq_pin_0_n, // External pin 0
    input wire logic irq_ack, // Core takes the offer
    input wire logic irq_return, // Core leaves a handler
    input wire logic irq_req, // Request to the core
    input wire logic [15:0] irq_vector, // Offered vector
    input wire logic [3:0] irq_source, // Offered source
    input wire logic [1:0] irq_level, // Offered level
    input wire logic ext0_request_flag, // Ext 0 request flag
    input wire logic [2:0] active_depth // Nesting depth
);
    // A take is an ack seen while the offer stands
    wire take = irq_req && irq_ack;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_take_drops_req: assert property (take |=> !irq_req)
        else $error("request still up after take");
    a_take_push_depth: assert property (take && active_depth < 3'h4 |=>
        active_depth == $past(active_depth) + 3'h1)
        else $error("take did not push a level");
    a_return_pop_depth: assert property (irq_return && !take &&
        active_depth != 3'h0 |=> active_depth == $past(active_depth) - 3'h1)
        else $error("return did not pop a level");
    a_global_blocks_req: assert property (!enable_reg_a[7] |-> !irq_req)
        else $error("request while globally disabled");
    a_vector_by_source: assert property (irq_req |-> irq_vector ==
        ((irq_source < 4'h9) ? {9'h0, irq_source, 3'h3} :
        {8'h0, irq_source, 4'h3} - 16'h40))
        else $error("vector does not match source");
    a_level_low_flags: assert property ((!ext0_trigger_type &&
        !ext_irq_pin_0_n) [*8] |=> ext0_request_flag)
        else $error("low level pin not flagged");
    a_level_high_clears: assert property ((!ext0_trigger_type &&
        ext_irq_pin_0_n) [*8] |=> !ext0_request_flag)
        else $error("level flag not following pin");
    a_edge_clear_take: assert property (take && irq_source == 4'h0 &&
        ext0_trigger_type |=> !ext0_request_flag)
        else $error("edge flag kept after take");
    a_edge_flag_holds: assert property (ext0_trigger_type &&
        ext0_request_flag && !take |=> ext0_request_flag || !ext0_trigger_type)
        else $error("edge flag lost without take");
    a_level_from_prio: assert property (irq_req && irq_source < 4'h6 &&
        $stable(prio_high_a) && $stable(prio_low_a) |->
        irq_level == {prio_high_a[irq_source], prio_low_a[irq_source]})
        else $error("offered level not from priority bits");
endmodule
bind interrupt_priority_controller irq_ctrl_checker chk (.clk, .rst_n,
    .enable_reg_a, .prio_low_a, .prio_high_a, .ext0_trigger_type,
    .ext_irq_pin_0_n, .irq_ack, .irq_return, .irq_req, .irq_vector,
    .irq_source, .irq_level, .ext0_request_flag, .active_depth);

// ### testbench/core_model.sv
`timescale 1ns/10ps
module core_model (
    input wire logic clk, // CPU clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic core_en, // Core accepts interrupts
    input wire logic slow, // Answer late when set
    input wire logic irq_req, // Request from the controller
    output logic irq_ack // Take pulse to the controller
);
    logic [1:0] wait_r; // Cycles the offer has stood
    // Count how long the offer stands, for the slow answer
    always_ff @(posedge clk) begin
        if (!rst_n || !irq_req || irq_ack) begin
            wait_r <= 2'h0;
        end else if (wait_r != 2'h3) begin
            wait_r <= wait_r + 2'h1;
        end
    end
    // Ack only a standing offer; drop it after the take edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= core_en && irq_req && !irq_ack &&
                (!slow || wait_r == 2'h3);
        end
    end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
    import irq_ctrl_pkg::*;
    logic clk = 1'b0; // CPU clock
    logic rst_n = 1'b0; // Reset, active low
    logic [11:0] en = 12'h0; // Enables by source
    logic [11:0] ph = 12'h0; // Priority high bits by source
    logic [11:0] pl = 12'h0; // Priority low bits by source
    logic [11:0] rq = 12'h0; // Requests by source, pins inverted
    logic g = 1'b0; // Global enable
    logic t0 = 1'b0; // Trigger type, ext 0
    logic t1 = 1'b0; // Trigger type, ext 1
    logic sx = 1'b0; // Serial request via tx or rx
    logic irq_return = 1'b0; // Handler return pulse
    logic power_down = 1'b0; // Core in power down
    logic core_en = 1'b0; // Core model takes offers
    logic slow = 1'b0; // Core model answers late
    logic irq_ack, irq_req, f0, f1, wakeup; // Design handshake and flags
    logic [15:0] irq_vector; // Offered vector
    logic [3:0] irq_source; // Offered source
    logic [1:0] irq_level; // Offered level
    logic [2:0] active_depth; // Nesting depth
    int n_fail = 0; // Mismatches
    int tests_run = 0; // Comparisons
    int seed = 40; // Random seed
    int pos[12] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 6, 13, 15};
    int rk[12] = '{0, 5, 9, 1, 6, 2, 7, 10, 3, 8, 4, 11};
    logic [15:0] vt[12] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
        16'h0023, 16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h0053,
        16'h0063, 16'h0073};
    // Place per-source bits at their register positions, {b, a}
    function automatic logic [15:0] spread(logic [11:0] v);
        logic [15:0] r;
        r = 16'h0;
        for (int i = 0; i < 12; i++) r[pos[i]] = v[i];
        return r;
    endfunction
    wire [15:0] en_w = spread(en); // Enable registers
    wire [15:0] ph_w = spread(ph); // Priority high registers
    wire [15:0] pl_w = spread(pl); // Priority low registers
    interrupt_priority_controller DUT (.clk(clk), .rst_n(rst_n),
        .enable_reg_a({g, en_w[6:0]}), .enable_reg_b(en_w[15:8]),
        .prio_low_a(pl_w[7:0]), .prio_high_a(ph_w[7:0]),
        .prio_low_b(pl_w[15:8]), .prio_high_b(ph_w[15:8]),
        .ext0_trigger_type(t0), .ext1_trigger_type(t1),
        .ext_irq_pin_0_n(~rq[0]), .ext_irq_pin_1_n(~rq[2]),
        .tmr0_overflow_flag(rq[1]), .tmr1_overflow_flag(rq[3]),
        .serial_tx_flag(rq[4] & sx), .serial_rx_flag(rq[4] & ~sx),
        .brownout_flag(rq[5]), .twowire_attention_flag(rq[6]),
        .keypad_flag(rq[7]), .cmp2_flag(rq[8]), .wdt_overflow_flag(rq[9]),
        .cmp1_flag(rq[10]), .bus_timer_flag(rq[11]), .irq_ack(irq_ack),
        .irq_return(irq_return), .power_down(power_down), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_source(irq_source),
        .irq_level(irq_level), .ext0_request_flag(f0),
        .ext1_request_flag(f1), .wakeup(wakeup),
        .active_depth(active_depth));
    core_model core (.clk(clk), .rst_n(rst_n), .core_en(core_en),
        .slow(slow), .irq_req(irq_req), .irq_ack(irq_ack));
    // Clock, 50 ns period
    initial forever #25 clk = ~clk;
    // Print counts and verdict, then stop
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bench model of arbitration and wakeup, compared with the design
    task automatic check_arb();
        int best;
        logic [11:0] el;
        el = g ? (en & rq) : 12'h0;
        best = -1;
        for (int l = 3; l >= 0; l--) for (int k = 0; k < 12; k++)
            if (best < 0 && el[rk[k]] && {ph[rk[k]], pl[rk[k]]} == l)
                best = rk[k];
        `CHK("req", best >= 0, irq_req)
        if (best >= 0) begin
            `CHK("source", best, irq_source)
            `CHK("vector", vt[best], irq_vector)
            `CHK("level", {ph[best], pl[best]}, irq_level)
        end
        if (g) `CHK("wake", |(el & (power_down ? 12'h7a5 : 12'hfff)), wakeup)
    endtask
    // Wait, bounded, for a nesting depth and compare it
    task automatic wait_depth(logic [2:0] d);
        for (int k = 0; k < 40 && active_depth !== d; k++) @(negedge clk);
        `CHK("depth", d, active_depth)
    endtask
    // Raise a request, let the core take it, then the source clears it
    task automatic take_src(int s, logic [2:0] d);
        @(posedge clk) rq[s] <= 1'b1;
        wait_depth(d);
        @(posedge clk) rq[s] <= 1'b0;
    endtask
    // Return from a handler and check the depth after
    task automatic ret(logic [2:0] d);
        @(posedge clk) irq_return <= 1'b1;
        @(posedge clk) irq_return <= 1'b0;
        repeat (4) @(posedge clk);
        wait_depth(d);
    endtask
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("req after reset", 1'b0, irq_req)
        // Random sources, enables, levels; pins in level mode
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            en <= 12'($random(seed));
            ph <= 12'($random(seed));
            pl <= 12'($random(seed));
            rq <= 12'($random(seed));
            g <= ($random(seed) & 3) != 0;
            sx <= 1'($random(seed));
            power_down <= 1'($random(seed));
            repeat (8) @(posedge clk);
            @(negedge clk) check_arb();
        end
        $display("arbitration test done");
        // Nesting: equal waits, higher preempts, top level is final
        @(posedge clk) {rq, g, power_down, core_en, slow} <= {12'h0, 4'hf};
        en <= 12'hfff;
        ph <= 12'h850;
        pl <= 12'h84a;
        take_src(1, 3'h1);
        @(posedge clk) rq[3] <= 1'b1;
        repeat (10) @(negedge clk);
        `CHK("equal level waits", 1'b0, irq_req)
        take_src(4, 3'h2);
        take_src(6, 3'h3);
        @(posedge clk) rq[11] <= 1'b1;
        repeat (10) @(negedge clk);
        `CHK("top level kept", 3'h3, active_depth)
        @(posedge clk) rq[11] <= 1'b0;
        ret(3'h2);
        ret(3'h1);
        `CHK("restored level blocks", 1'b0, irq_req)
        ret(3'h1);
        @(posedge clk) rq[3] <= 1'b0;
        ret(3'h0);
        $display("nesting test done");
        // Edge mode: high, then low, each over a machine cycle
        @(posedge clk) {core_en, slow, t0, en, ph, pl} <= {3'h1, 12'h5, 24'h0};
        repeat (12) @(posedge clk);
        @(negedge clk) `CHK("edge flag idle", 1'b0, f0)
        @(posedge clk) rq[0] <= 1'b1;
        repeat (14) @(negedge clk);
        `CHK("edge flag", 1'b1, f0)
        `CHK("edge source", 4'h0, irq_source)
        @(posedge clk) rq[0] <= 1'b0;
        repeat (14) @(negedge clk);
        `CHK("edge flag held", 1'b1, f0)
        @(posedge clk) core_en <= 1'b1;
        wait_depth(3'h1);
        `CHK("edge flag cleared", 1'b0, f0)
        ret(3'h0);
        $display("edge test done");
        // Level mode: pin held low until taken and past the return
        @(posedge clk) rq[2] <= 1'b1;
        wait_depth(3'h1);
        `CHK("level flag", 1'b1, f1)
        ret(3'h1);
        @(posedge clk) rq[2] <= 1'b0;
        repeat (14) @(negedge clk);
        `CHK("level flag released", 1'b0, f1)
        ret(3'h0);
        $display("level test done");
        report_and_stop();
    end
endmodule
